/* hdl/cptr_regs.sv */
// register bank: monitor tx gain and ring delay / ring interval check
`timescale 1ns/10ps
// Behaviour
// [RQ1] tx monitor gain linear in code over 64
// [RQ2] code 0x40 unity, 0xFF about plus 12 dB
// [RQ3] zero code mutes tx monitor contribution
// [RQ4] delay valid ring by selected delay code
// [RQ5] delay codes 000 none, 001 256ms, 010 512ms
// [RQ6] ring invalid when interval timer exceeds maximum
// [RQ7] delay code msb comes from input pin
// [RQ8] registers read back last written value
module cptr_regs
	import cptr_pkg::*;
#(
	parameter int DLY_STEP_CYC = CPTR_DLY_STEP_CYC,
	parameter int RMX_STEP_CYC = CPTR_RMX_STEP_CYC,
	parameter logic [5:0] RING_START = 6'h3F
) (
	// clock, reset, enable
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         clkEn,
	// register port
	input  wire cptr_bus_type bus,
	output logic [7:0]        rdData,
	// tx monitor path
	input  wire logic signed [15:0] txSample,
	output logic signed [15:0]      callProgressMonitorOut,
	// ring qualification
	input  wire logic         ringDelayMsb,
	input  wire logic         lineEvent,
	input  wire logic         ringDetected,
	output logic              ringValid,
	output logic              ringInvalid
);
	logic [7:0]         txGain_reg;
	logic [7:0]         ringChk_reg;
	cptr_state_type     state_reg;
	cptr_state_type     state_next;
	logic [5:0]         ivTimer_reg;
	logic [31:0]        stepCnt_reg;
	logic [31:0]        dlyCnt_reg;
	logic [31:0]        dlyTarget;
	logic [2:0]         dlyCode;
	logic signed [24:0] prod;
	logic               tick;
	logic               wrGain;
	logic               wrRing;
	logic               rdGain;
	logic               rdRing;
	logic               tooLong;
	logic               delayDone;

	// true when a strobe addresses the given register
	function automatic logic hits(
		input logic       strobe,
		input logic [7:0] addr,
		input logic [7:0] target
	);
		return strobe && (addr == target);
	endfunction : hits

	// scale back by 64 and clip to the 16-bit output range
	function automatic logic signed [15:0] clip(
		input logic signed [24:0] p
	);
		logic signed [24:0] scaled;
		scaled = p >>> CPTR_GAIN_SHIFT;
		if (scaled > 25'(CPTR_OUT_MAX))
			return 16'(CPTR_OUT_MAX);
		else if (scaled < 25'(CPTR_OUT_MIN))
			return 16'(CPTR_OUT_MIN);
		else
			return 16'(scaled);
	endfunction : clip

	// delay code to cycles; codes above 010 are clamped to 512 ms
	function automatic logic [31:0] delayCycles(
		input logic [2:0] code
	);
		unique case (code)
			3'h0:    return 32'h0; // [RQ5]
			3'h1:    return 32'(DLY_STEP_CYC); // [RQ5]
			default: return 32'(2 * DLY_STEP_CYC); // [RQ5]
		endcase
	endfunction : delayCycles

	// register port decode
	assign wrGain = hits(clkEn && bus.wr, bus.addr, CPTR_ADDR_TX_GAIN);
	assign wrRing = hits(clkEn && bus.wr, bus.addr, CPTR_ADDR_RING_CHK);
	assign rdGain = hits(bus.rd, bus.addr, CPTR_ADDR_TX_GAIN);
	assign rdRing = hits(bus.rd, bus.addr, CPTR_ADDR_RING_CHK);

	// gain register
	always_ff @(posedge mclk) begin
		if (rst)
			txGain_reg <= CPTR_TX_GAIN_RESET;
		else if (wrGain)
			txGain_reg <= bus.wdata; // [RQ8]
	end

	// ring check register
	always_ff @(posedge mclk) begin
		if (rst)
			ringChk_reg <= CPTR_RING_CHK_RESET;
		else if (wrRing)
			ringChk_reg <= bus.wdata; // [RQ8]
	end

	// read data one cycle after strobe, zero otherwise
	always_ff @(posedge mclk) begin
		if (rst)
			rdData <= 8'h00;
		else if (clkEn) begin
			if (rdGain)
				rdData <= txGain_reg; // [RQ8]
			else if (rdRing)
				rdData <= ringChk_reg; // [RQ8]
			else
				rdData <= 8'h00;
		end
	end

	// gain = code/64, so 0x40 is unity and 0x00 gives zero
	assign prod = 25'(txSample) *
		25'($signed({1'b0, txGain_reg})); // [RQ1] [RQ2]

	// monitor output, saturated rather than wrapped
	always_ff @(posedge mclk) begin
		if (rst)
			callProgressMonitorOut <= 16'sh0000;
		else if (clkEn) begin
			if (txGain_reg == CPTR_TX_MUTE)
				callProgressMonitorOut <= 16'sh0000; // [RQ3]
			else
				callProgressMonitorOut <= clip(prod); // [RQ1] [RQ2]
		end
	end

	assign dlyCode = {ringDelayMsb,
		ringChk_reg[CPTR_DLY_MSB:CPTR_DLY_LSB]}; // [RQ4] [RQ7]

	assign dlyTarget = delayCycles(dlyCode); // [RQ5]

	// 2 ms tick for the interval timer
	assign tick = (stepCnt_reg == 32'(RMX_STEP_CYC - 1));

	// tick prescaler, restarted by each line event
	always_ff @(posedge mclk) begin
		if (rst)
			stepCnt_reg <= 32'h0;
		else if (clkEn) begin
			if (lineEvent || tick)
				stepCnt_reg <= 32'h0;
			else
				stepCnt_reg <= stepCnt_reg + 32'h1;
		end
	end

	// interval timer loaded on line event, decremented each tick until it holds at zero
	always_ff @(posedge mclk) begin
		if (rst)
			ivTimer_reg <= 6'h00;
		else if (clkEn) begin
			if (lineEvent)
				ivTimer_reg <= RING_START; // [RQ6]
			else if (tick && ivTimer_reg != 6'h00)
				ivTimer_reg <= ivTimer_reg - 6'h01; // [RQ6]
		end
	end

	// event arrived while the timer is still above the maximum
	assign tooLong = lineEvent &&
		(ivTimer_reg > ringChk_reg[CPTR_RMX_MSB:0]); // [RQ6]

	assign delayDone = (dlyCnt_reg >= dlyTarget); // [RQ4]

	// qualification, delay and valid sequence
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CPTR_IDLE: begin
				if (lineEvent)
					state_next = CPTR_QUAL;
			end
			CPTR_QUAL: begin
				if (tooLong)
					state_next = CPTR_IDLE; // [RQ6]
				else if (ringDetected)
					state_next = CPTR_DELAY;
			end
			CPTR_DELAY: begin
				if (delayDone)
					state_next = CPTR_VALID; // [RQ4]
			end
			CPTR_VALID: begin
				if (!ringDetected)
					state_next = CPTR_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst)
			state_reg <= CPTR_IDLE;
		else if (clkEn)
			state_reg <= state_next;
	end

	// delay counter, cleared while qualifying
	always_ff @(posedge mclk) begin
		if (rst)
			dlyCnt_reg <= 32'h0;
		else if (clkEn) begin
			if (state_reg == CPTR_QUAL)
				dlyCnt_reg <= 32'h0;
			else if (state_reg == CPTR_DELAY && !delayDone)
				dlyCnt_reg <= dlyCnt_reg + 32'h1; // [RQ4]
		end
	end

	// valid level follows the valid state
	always_ff @(posedge mclk) begin
		if (rst)
			ringValid <= 1'b0;
		else if (clkEn)
			ringValid <= (state_next == CPTR_VALID); // [RQ4]
	end

	// one-cycle invalid pulse
	always_ff @(posedge mclk) begin
		if (rst)
			ringInvalid <= 1'b0;
		else if (clkEn)
			ringInvalid <= (state_reg == CPTR_QUAL) && tooLong; // [RQ6]
	end
endmodule : cptr_regs

/* hdl/cptr_pkg.sv */
// package for the call progress tx gain and ring delay register bank
package cptr_pkg;
	localparam logic [7:0] CPTR_ADDR_TX_GAIN   = 8'h15;
	localparam logic [7:0] CPTR_ADDR_RING_CHK  = 8'h16;
	localparam logic [7:0] CPTR_TX_GAIN_RESET  = 8'h40;
	localparam logic [7:0] CPTR_RING_CHK_RESET = 8'h00;
	localparam logic [7:0] CPTR_TX_UNITY       = 8'h40;
	localparam logic [7:0] CPTR_TX_MUTE        = 8'h00;
	localparam int CPTR_DLY_MSB = 7;
	localparam int CPTR_DLY_LSB = 6;
	localparam int CPTR_RMX_MSB = 5;
	localparam int CPTR_GAIN_SHIFT = 6;
	localparam int CPTR_OUT_MAX = 32767;
	localparam int CPTR_OUT_MIN = -32768;
	localparam int CPTR_CLK_HZ = 40_000_000;
	localparam int CPTR_DLY_STEP_MS = 256;
	localparam int CPTR_RMX_STEP_US = 2000;
	localparam int CPTR_DLY_STEP_CYC = CPTR_CLK_HZ / 1000 * CPTR_DLY_STEP_MS;
	localparam int CPTR_RMX_STEP_CYC = CPTR_CLK_HZ / 1000000 * CPTR_RMX_STEP_US;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cptr_bus_type;

	typedef enum logic [1:0] {
		CPTR_IDLE  = 2'b00,
		CPTR_QUAL  = 2'b01,
		CPTR_DELAY = 2'b11,
		CPTR_VALID = 2'b10
	} cptr_state_type;
endpackage : cptr_pkg

/* tb/cptr_regs_properties.sv */
// assertion checker for the tx gain and ring check registers
`timescale 1ns/10ps
module cptr_regs_properties
	import cptr_pkg::*;
(
	// clock and control
	input wire logic mclk, rst, clkEn,
	// register port
	input wire cptr_bus_type bus,
	input wire logic [7:0] rdData,
	// monitor path
	input wire logic signed [15:0] txSample, callProgressMonitorOut,
	// ring side
	input wire logic ringDelayMsb, lineEvent, ringDetected, ringValid,
	input wire logic ringInvalid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [7:0] g, r;
	// shadow of what software last wrote
	always_ff @(posedge mclk) begin
		if (rst) begin
			g <= 8'h40;
			r <= 8'h00;
		end else if (clkEn && bus.wr) begin
			if (bus.addr == 8'h15) g <= bus.wdata;
			if (bus.addr == 8'h16) r <= bus.wdata;
		end
	end
	a_gain_read_back: assert property (clkEn && bus.rd && bus.addr == 8'h15
		|=> rdData == g) else $error("gain readback");
	a_ring_read_back: assert property (clkEn && bus.rd && bus.addr == 8'h16
		|=> rdData == r) else $error("ring readback");
	a_idle_read_zero: assert property (clkEn && !bus.rd
		|=> rdData == 8'h00) else $error("idle read data");
	a_mute_out: assert property (clkEn && g == 8'h00
		|=> callProgressMonitorOut == 0) else $error("mute");
	a_unity_gain: assert property (clkEn && g == 8'h40
		|=> callProgressMonitorOut == $past(txSample)) else $error("unity");
	a_half_gain: assert property (clkEn && g == 8'h20
		|=> callProgressMonitorOut == ($past(txSample) >>> 1)) else $error("half");
	a_invalid_pulse: assert property (ringInvalid |=> !ringInvalid)
		else $error("invalid pulse");
	a_valid_cause: assert property ($rose(ringValid) |-> $past(ringDetected))
		else $error("valid cause");
	a_delay_held: assert property ($rose(ringDetected) && r[7:6] == 2'b01
		&& !ringDelayMsb |=> !ringValid[*8]) else $error("early valid");
endmodule : cptr_regs_properties
bind cptr_regs cptr_regs_properties i_chk (.mclk, .rst, .clkEn, .bus, .rdData,
	.txSample, .callProgressMonitorOut, .ringDelayMsb, .lineEvent,
	.ringDetected, .ringValid, .ringInvalid);

/* tb/tb_top.sv */
// self-checking bench for the tx gain and ring check registers
`timescale 1ns/10ps
module tb_top
	import cptr_pkg::*;
;
	logic mclk, rst, clkEn, dMsb, ev, det, valid, inval;
	cptr_bus_type bus;
	logic [7:0] rdData;
	logic signed [15:0] tx, out;
	int error_cnt, n_checks, n;
	cptr_regs #(.DLY_STEP_CYC(20), .RMX_STEP_CYC(4)) i_dut (.mclk, .rst,
		.clkEn, .bus, .rdData, .txSample(tx), .callProgressMonitorOut(out),
		.ringDelayMsb(dMsb), .lineEvent(ev), .ringDetected(det),
		.ringValid(valid), .ringInvalid(inval));
	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	task chk(string nm, logic [15:0] e, s);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task wr(logic [7:0] a, d);
		@(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk) bus.wr <= 1'b0;
	endtask : wr
	task rd(logic [7:0] a, e);
		@(posedge mclk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk) bus.rd <= 1'b0;
		#1 chk("rdData", {8'h00, e}, {8'h00, rdData});
	endtask : rd
	task gain(logic [7:0] c, logic [15:0] e);
		wr(8'h15, c);
		repeat (2) @(posedge mclk);
		#1 chk("out", e, out);
	endtask : gain
	task pulse;
		@(posedge mclk) ev <= 1'b1;
		@(posedge mclk) ev <= 1'b0;
	endtask : pulse
	task close_out;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	initial begin
		repeat (3000) @(posedge mclk);
		error_cnt++;
		close_out;
	end
	initial begin
		{error_cnt, n_checks, rst, clkEn, dMsb, ev, det} = '0;
		{rst, clkEn, tx, bus} = {2'b11, 16'sd1000, 18'h0};
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		rd(8'h15, 8'h40);
		rd(8'h16, 8'h00);
		wr(8'h16, 8'h7F);
		rd(8'h16, 8'h7F);
		rd(8'h17, 8'h00);
		gain(8'h40, 16'h03E8);
		gain(8'hFF, 16'h0F90);
		gain(8'h7F, 16'h07C0);
		gain(8'h20, 16'h01F4);
		gain(8'h10, 16'h00FA);
		tx <= 16'sh7000;
		gain(8'hFF, 16'h7FFF);
		tx <= -16'sh7000;
		gain(8'hFF, 16'h8000);
		tx <= 16'sd1000;
		gain(8'h00, 16'h0000);
		clkEn <= 1'b0;
		wr(8'h15, 8'h55);
		clkEn <= 1'b1;
		rd(8'h15, 8'h00);
		wr(8'h16, 8'h40);
		pulse;
		det <= 1'b1;
		for (n = 0; n < 90 && valid !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		chk("delay", 16'h0001, {15'h0, n >= 20 && valid === 1'b1});
		det <= 1'b0;
		pulse;
		pulse;
		#1;
		for (n = 0; n < 6 && inval !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		chk("invalid", 16'h0001, {15'h0, inval === 1'b1});
		close_out;
	end
endmodule : tb_top
